/* abu_address_breakpoint_unit.sv */
`timescale 1ns/1ps
`include "abu_defines.svh"

module abu_address_breakpoint_unit #(
    parameter logic [7:0] SWI_OPCODE = 8'h00    // Forced opcode value, arbitrary default
) (
    input  wire logic              core_clk,            // Bus clock, 250 MHz
    input  wire logic              rst_b,               // Synchronous reset, active low
    input  wire logic [4:0]        avs_address,         // Byte address
    input  wire logic              avs_read,            // Read request
    input  wire logic              avs_write,           // Write request
    input  wire logic [31:0]       avs_writedata,       // Write data
    input  wire logic [3:0]        avs_byteenable,      // Byte enables
    output logic [31:0]            avs_readdata,        // Read data, registered
    output logic                   avs_waitrequest,     // Stall
    input  wire abu_pkg::abu_cpu_s cpu_bus,             // CPU program address side
    input  wire logic              monitor_mode,        // Monitor mode latched
    input  wire logic              low_power,           // Wait or stop mode
    output abu_pkg::abu_siu_s      siu_out,             // Toward integration unit
    output logic [7:0]             software_interrupt_opcode, // Forced opcode
    output logic                   irq                  // Level interrupt
);

    logic [7:0]          break_address_high_reg;
    logic [7:0]          break_address_low_reg;
    logic                break_enable_reg;
    logic                break_active_reg;
    logic                watchdog_off_reg;
    logic                flag_clear_reg;
    logic [1:0]          irq_status_reg;
    logic [1:0]          irq_mask_reg;
    logic                armed_reg;
    logic                pending_reg;
    logic                request_reg;
    logic [15:0]         vector_reg;
    logic                ack_reg;
    logic [31:0]         readdata_reg;
    abu_pkg::abu_state_e state_reg;
    abu_pkg::abu_state_e state_next;

    logic                access;
    logic                wr_take;
    logic                rd_take;
    logic                addr_match;
    logic                opcode_hit;
    logic                fire;
    logic                sw_break;
    logic                rti_end;
    logic [1:0]          irq_set;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction

    // Avalon slave: one wait cycle, answer on the second
    assign access          = avs_read | avs_write;
    assign avs_waitrequest = access & ~ack_reg;
    assign wr_take         = avs_write & ack_reg;
    assign rd_take         = avs_read & ack_reg;
    assign avs_readdata    = readdata_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            readdata_reg <= 32'h0000_0000;
            if (hit(avs_address, `ABU_OFF_CTRL_STATUS)) begin
                readdata_reg[`ABU_BIT_ENABLE] <= break_enable_reg;
                readdata_reg[`ABU_BIT_ACTIVE] <= break_active_reg;
            end
            if (hit(avs_address, `ABU_OFF_ADDR_HIGH)) begin
                readdata_reg[7:0] <= break_address_high_reg;
            end
            if (hit(avs_address, `ABU_OFF_ADDR_LOW)) begin
                readdata_reg[7:0] <= break_address_low_reg;
            end
            if (hit(avs_address, `ABU_OFF_AUXILIARY)) begin
                readdata_reg[`ABU_BIT_WDOG_OFF] <= watchdog_off_reg;
            end
            if (hit(avs_address, `ABU_OFF_FLAG_CTRL)) begin
                readdata_reg[`ABU_BIT_FLAG_CLEAR] <= flag_clear_reg;
            end
            if (hit(avs_address, `ABU_OFF_IRQ_STATUS)) begin
                readdata_reg[1:0] <= irq_status_reg;
            end
            if (hit(avs_address, `ABU_OFF_IRQ_MASK)) begin
                readdata_reg[1:0] <= irq_mask_reg;
            end
        end
    end

    // Address registers; a write re-arms matching
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            break_address_high_reg <= `ABU_RST_BYTE;
            break_address_low_reg  <= `ABU_RST_BYTE;
        end else if (wr_take && avs_byteenable[0]) begin
            if (hit(avs_address, `ABU_OFF_ADDR_HIGH)) begin
                break_address_high_reg <= avs_writedata[7:0];
            end
            if (hit(avs_address, `ABU_OFF_ADDR_LOW)) begin
                break_address_low_reg <= avs_writedata[7:0];
            end
        end
    end

    // Control bits
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            break_enable_reg <= 1'b0;
            watchdog_off_reg <= 1'b0;
            flag_clear_reg   <= 1'b0;
            irq_mask_reg     <= `ABU_RST_IRQ;
        end else if (wr_take && avs_byteenable[0]) begin
            if (hit(avs_address, `ABU_OFF_CTRL_STATUS)) begin
                break_enable_reg <= avs_writedata[`ABU_BIT_ENABLE];
            end
            if (hit(avs_address, `ABU_OFF_AUXILIARY)) begin
                watchdog_off_reg <= avs_writedata[`ABU_BIT_WDOG_OFF];
            end
            if (hit(avs_address, `ABU_OFF_FLAG_CTRL)) begin
                flag_clear_reg <= avs_writedata[`ABU_BIT_FLAG_CLEAR];
            end
            if (hit(avs_address, `ABU_OFF_IRQ_MASK)) begin
                irq_mask_reg <= avs_writedata[1:0];
            end
        end
    end

    // Stalled program counter in wait or stop never matches
    assign addr_match = break_enable_reg & armed_reg & cpu_bus.valid & ~low_power
                      & (cpu_bus.addr == {break_address_high_reg, break_address_low_reg});
    assign sw_break   = wr_take & avs_byteenable[0] & hit(avs_address, `ABU_OFF_CTRL_STATUS)
                      & avs_writedata[`ABU_BIT_ACTIVE];
    assign opcode_hit = addr_match & cpu_bus.opcode;
    assign fire       = (state_reg == abu_pkg::ABU_ST_IDLE)
                      & (opcode_hit | (pending_reg & cpu_bus.boundary));
    assign rti_end    = (state_reg == abu_pkg::ABU_ST_BREAK) & cpu_bus.return_from_interrupt;

    // Active flag: a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            break_active_reg <= 1'b0;
        end else if (addr_match || sw_break) begin
            break_active_reg <= 1'b1;
        end else if (wr_take && avs_byteenable[0] && hit(avs_address, `ABU_OFF_CTRL_STATUS)) begin
            break_active_reg <= 1'b0;
        end
    end

    // A taken break disarms the same address until software loads a new one
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            armed_reg <= 1'b1;
        end else if (wr_take && avs_byteenable[0]
                     && (hit(avs_address, `ABU_OFF_ADDR_HIGH) || hit(avs_address, `ABU_OFF_ADDR_LOW))) begin
            armed_reg <= 1'b1;
        end else if (addr_match) begin
            armed_reg <= 1'b0;
        end
    end

    // Operand matches and software breaks wait for the instruction boundary
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pending_reg <= 1'b0;
        end else if (fire) begin
            pending_reg <= 1'b0;
        end else if ((addr_match && !cpu_bus.opcode) || sw_break) begin
            pending_reg <= 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            abu_pkg::ABU_ST_IDLE: begin
                if (fire) begin
                    state_next = abu_pkg::ABU_ST_BREAK;
                end
            end
            abu_pkg::ABU_ST_BREAK: begin
                if (rti_end) begin
                    state_next = abu_pkg::ABU_ST_IDLE;
                end
            end
            default: begin
                state_next = abu_pkg::ABU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= abu_pkg::ABU_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request and vector registered together so they arrive aligned
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            request_reg <= 1'b0;
            vector_reg  <= `ABU_VEC_NORMAL;
        end else begin
            request_reg <= fire;
            vector_reg  <= monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
        end
    end

    assign software_interrupt_opcode   = SWI_OPCODE;
    assign siu_out.breakpoint_request  = request_reg;
    assign siu_out.vector              = vector_reg;
    assign siu_out.in_break            = (state_reg == abu_pkg::ABU_ST_BREAK);
    assign siu_out.status_clear_allow  = (state_reg != abu_pkg::ABU_ST_BREAK) | flag_clear_reg;
    assign siu_out.timer_hold          = (state_reg == abu_pkg::ABU_ST_BREAK);
    assign siu_out.watchdog_disable    = (state_reg == abu_pkg::ABU_ST_BREAK) & monitor_mode
                                       & watchdog_off_reg;

    // Sticky events; a read clears only the bits it returned, so a late event is never lost
    assign irq_set = {rti_end, fire};

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq_status_reg <= `ABU_RST_IRQ;
        end else if (rd_take && hit(avs_address, `ABU_OFF_IRQ_STATUS)) begin
            irq_status_reg <= (irq_status_reg & ~readdata_reg[1:0]) | irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // Checks
    chk_match_request: assert property (@(posedge core_clk) disable iff (!rst_b)
        (opcode_hit && state_reg == abu_pkg::ABU_ST_IDLE) |=> siu_out.breakpoint_request)
        else $error("opcode match without request");

    chk_vector_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        siu_out.breakpoint_request |-> siu_out.vector == ($past(monitor_mode) ? 16'hfefc : 16'hfffc))
        else $error("wrong break vector");

    chk_soft_break: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sw_break && state_reg == abu_pkg::ABU_ST_IDLE) ##1 cpu_bus.boundary |=> siu_out.breakpoint_request)
        else $error("software break not taken at boundary");

    chk_operand_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pending_reg && !cpu_bus.boundary && !opcode_hit) |=> !siu_out.breakpoint_request)
        else $error("operand break before boundary");

    chk_rti_ends: assert property (@(posedge core_clk) disable iff (!rst_b)
        (siu_out.in_break && cpu_bus.return_from_interrupt) |=> !siu_out.in_break && !siu_out.timer_hold)
        else $error("break not ended by return");

    chk_no_rebreak: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!armed_reg && !wr_take) |=> !pending_reg || $past(pending_reg) || $past(sw_break))
        else $error("disarmed address broke again");

    chk_flag_guard: assert property (@(posedge core_clk) disable iff (!rst_b)
        (siu_out.in_break && !flag_clear_reg) |-> !siu_out.status_clear_allow)
        else $error("flags clearable in break");

    chk_timer_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        siu_out.breakpoint_request |-> siu_out.timer_hold)
        else $error("timer not held in break");

    chk_watchdog_off: assert property (@(posedge core_clk) disable iff (!rst_b)
        (siu_out.in_break && monitor_mode && watchdog_off_reg) |-> siu_out.watchdog_disable)
        else $error("watchdog not disabled");

    chk_enable_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        !break_enable_reg |-> !addr_match)
        else $error("match while disabled");

    chk_active_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        addr_match |=> break_active_reg)
        else $error("active bit not set on match");

    chk_low_power: assert property (@(posedge core_clk) disable iff (!rst_b)
        low_power |-> !addr_match)
        else $error("match in low power mode");

    chk_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(access) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer latency wrong");

    chk_request_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
        siu_out.breakpoint_request |=> !siu_out.breakpoint_request)
        else $error("break request longer than one cycle");

    chk_request_break: assert property (@(posedge core_clk) disable iff (!rst_b)
        siu_out.breakpoint_request |-> siu_out.in_break)
        else $error("request outside break state");

    chk_opcode_now: assert property (@(posedge core_clk) disable iff (!rst_b)
        (opcode_hit && state_reg == abu_pkg::ABU_ST_IDLE) |=> siu_out.in_break)
        else $error("opcode match did not stop the instruction");

    chk_operand_boundary: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pending_reg && cpu_bus.boundary && state_reg == abu_pkg::ABU_ST_IDLE) |=> siu_out.breakpoint_request)
        else $error("pending break not taken at boundary");

    chk_sw_pending: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sw_break && !fire) |=> pending_reg)
        else $error("software break not held for boundary");

    chk_sw_active: assert property (@(posedge core_clk) disable iff (!rst_b)
        sw_break |=> break_active_reg)
        else $error("software break did not set active bit");

    chk_active_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wr_take && avs_byteenable[0] && hit(avs_address, `ABU_OFF_CTRL_STATUS)
         && !avs_writedata[`ABU_BIT_ACTIVE] && !addr_match) |=> !break_active_reg)
        else $error("active bit not cleared by write of zero");

    chk_disarm_match: assert property (@(posedge core_clk) disable iff (!rst_b)
        (addr_match && !wr_take) |=> !armed_reg)
        else $error("match did not disarm the address");

    chk_flag_free: assert property (@(posedge core_clk) disable iff (!rst_b)
        !siu_out.in_break |-> siu_out.status_clear_allow)
        else $error("flags locked outside break");

    chk_wdog_normal: assert property (@(posedge core_clk) disable iff (!rst_b)
        !monitor_mode |-> !siu_out.watchdog_disable)
        else $error("watchdog disabled outside monitor mode");

    chk_enable_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wr_take && avs_byteenable[0] && hit(avs_address, `ABU_OFF_CTRL_STATUS)
         && !avs_writedata[`ABU_BIT_ENABLE]) |=> !break_enable_reg)
        else $error("enable bit not cleared by write of zero");

    chk_irq_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
        (irq_status_reg[`ABU_BIT_IRQ_TAKEN] && !rd_take) |=> irq_status_reg[`ABU_BIT_IRQ_TAKEN])
        else $error("break status bit dropped without a read");

    chk_irq_no_loss: assert property (@(posedge core_clk) disable iff (!rst_b)
        (avs_read && !ack_reg && hit(avs_address, `ABU_OFF_IRQ_STATUS) && fire
         && !irq_status_reg[`ABU_BIT_IRQ_TAKEN]) |=> ##1 irq_status_reg[`ABU_BIT_IRQ_TAKEN])
        else $error("break event lost by status read");

    cov_opcode_break: cover property (@(posedge core_clk) disable iff (!rst_b)
        opcode_hit ##1 siu_out.breakpoint_request ##[1:50] cpu_bus.return_from_interrupt);
    cov_soft_break: cover property (@(posedge core_clk) disable iff (!rst_b)
        sw_break ##[1:20] siu_out.breakpoint_request);
    cov_monitor_wdog: cover property (@(posedge core_clk) disable iff (!rst_b)
        siu_out.watchdog_disable);
    cov_operand_break: cover property (@(posedge core_clk) disable iff (!rst_b)
        (addr_match && !cpu_bus.opcode) ##[1:4] siu_out.breakpoint_request);
    cov_irq_read: cover property (@(posedge core_clk) disable iff (!rst_b)
        rd_take && hit(avs_address, `ABU_OFF_IRQ_STATUS) && irq);

endmodule

/* abu_cpu_model.sv */
`timescale 1ns/1ps
module abu_cpu_model (
    input  wire logic              core_clk,   // Bus clock
    input  wire logic              rst_b,      // Synchronous reset, active low
    input  wire logic              run,        // Let the program advance
    input  wire logic              load,       // Restart at start_addr
    input  wire logic [15:0]       start_addr, // Restart address
    input  wire logic              ret,        // Break routine may return
    input  wire logic              low_power,  // Wait or stop mode
    input  wire abu_pkg::abu_siu_s siu_out,    // Break outputs of the unit
    output abu_pkg::abu_cpu_s      cpu_bus     // Program address side
);
    logic [15:0] pc_reg;
    logic        step;

    // Two-byte instructions, opcode at even address; frozen in break and low power
    assign step = run & ~low_power & ~siu_out.in_break & ~cpu_bus.return_from_interrupt & ~load;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pc_reg  <= 16'h0000;
            cpu_bus <= '0;
        end else begin
            cpu_bus.return_from_interrupt <= siu_out.in_break & ret & ~cpu_bus.return_from_interrupt;
            if (load) begin
                pc_reg <= start_addr;
            end else if (step) begin
                pc_reg <= pc_reg + 16'h0001;
            end
            cpu_bus.valid    <= step;
            cpu_bus.opcode   <= step & ~pc_reg[0];
            cpu_bus.boundary <= step & ~pc_reg[0];
            // Idle address shows the inverse of the previous cycle's address, so it toggles each idle cycle
            cpu_bus.addr     <= step ? pc_reg : ~cpu_bus.addr;
        end
    end
endmodule

/* abu_defines.svh */
`ifndef ABU_DEFINES_SVH
`define ABU_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave
`define ABU_OFF_CTRL_STATUS  5'h00
`define ABU_OFF_ADDR_HIGH    5'h04
`define ABU_OFF_ADDR_LOW     5'h08
`define ABU_OFF_AUXILIARY    5'h0c
`define ABU_OFF_FLAG_CTRL    5'h10
`define ABU_OFF_IRQ_STATUS   5'h14
`define ABU_OFF_IRQ_MASK     5'h18

// Field positions
`define ABU_BIT_ENABLE       7
`define ABU_BIT_ACTIVE       6
`define ABU_BIT_WDOG_OFF     0
`define ABU_BIT_FLAG_CLEAR   7
`define ABU_BIT_IRQ_TAKEN    0
`define ABU_BIT_IRQ_ENDED    1

// Reset values
`define ABU_RST_BYTE         8'h00
`define ABU_RST_IRQ          2'h0

// Break vectors, normal and monitor mode
`define ABU_VEC_NORMAL       16'hfffc
`define ABU_VEC_MONITOR      16'hfefc

// Bus answer latency in cycles after the request is first seen
`define ABU_BUS_LATENCY      1

`endif

/* abu_pkg.sv */
package abu_pkg;

    // Program-address side of the CPU core, sampled on core_clk
    typedef struct packed {
        logic [15:0] addr;       // CPU generated program address
        logic        valid;      // Address advanced this cycle
        logic        opcode;     // Address is an opcode fetch
        logic        boundary;   // Next instruction about to begin
        logic        return_from_interrupt;        // Return from interrupt completed
    } abu_cpu_s;

    // Outputs toward the system integration unit and peers
    typedef struct packed {
        logic        breakpoint_request; // One-cycle break request
        logic [15:0] vector;             // Vector for the forced interrupt
        logic        in_break;           // Break state
        logic        status_clear_allow; // Module flags may be cleared
        logic        timer_hold;         // Timer counter must not advance
        logic        watchdog_disable;   // Watchdog off during break in monitor mode, if enabled
    } abu_siu_s;

    typedef enum logic [1:0] {
        ABU_ST_IDLE  = 2'b01,
        ABU_ST_BREAK = 2'b10
    } abu_state_e;

endpackage

/* testbench.sv */
`timescale 1ns/1ps
`include "abu_defines.svh"
module testbench;
    logic              core_clk;
    logic              rst_b;
    logic [4:0]        avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    abu_pkg::abu_cpu_s cpu_bus;
    abu_pkg::abu_siu_s siu_out;
    logic              monitor_mode;
    logic              low_power;
    logic [7:0]        swi_op;
    logic              irq;
    logic              run;
    logic              load;
    logic              ret;
    logic [15:0]       start_addr;
    logic [15:0]       prev_addr;
    int                req_count;
    int                fail_count;
    int                n_compared;

    abu_address_breakpoint_unit #(.SWI_OPCODE(8'h5a)) u_dut (
        .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_bus(cpu_bus),
        .monitor_mode(monitor_mode), .low_power(low_power), .siu_out(siu_out),
        .software_interrupt_opcode(swi_op), .irq(irq)
    );

    abu_cpu_model u_cpu (
        .core_clk(core_clk), .rst_b(rst_b), .run(run), .load(load), .start_addr(start_addr),
        .ret(ret), .low_power(low_power), .siu_out(siu_out), .cpu_bus(cpu_bus)
    );

    always #2 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        prev_addr <= cpu_bus.addr;
        if (siu_out.breakpoint_request === 1'b1) begin
            req_count <= req_count + 1;
        end
    end

    task report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task timeout;
        fail_count++;
        report_and_stop;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp({15'h0000, got}, {15'h0000, exp});
    endtask

    // Entered just after a rising edge; leaves one idle edge so no signal is assigned twice at once
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                       output logic [7:0] q);
        int i;
        avs_address    <= a;
        avs_write      <= w;
        avs_read       <= ~w;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= be;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) timeout;
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, 4'h1, q);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, 4'hf, q);
        cmp({8'h00, q}, {8'h00, e});
    endtask

    task automatic wait_req;
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge core_clk);
            if (siu_out.breakpoint_request === 1'b1) break;
        end
        if (i == 200) timeout;
    endtask

    task automatic end_break;
        int i;
        ret <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (siu_out.in_break === 1'b0) break;
        end
        if (i == 50) timeout;
        ret <= 1'b0;
    endtask

    task automatic restart;
        load <= 1'b1;
        @(posedge core_clk);
        load <= 1'b0;
    endtask

    task automatic quiet(input int n);
        int c0;
        c0 = req_count;
        repeat (n) @(posedge core_clk);
        cmp(16'(req_count - c0), 16'h0000);
    endtask

    initial begin
        int         k;
        logic [7:0] q;
        core_clk = 1'b0;
        rst_b = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        monitor_mode = 1'b0;
        low_power = 1'b0;
        run = 1'b0;
        load = 1'b0;
        ret = 1'b0;
        start_addr = 16'h1230;
        req_count = 0;
        fail_count = 0;
        n_compared = 0;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        // All registers and the unmapped word read zero
        for (k = 0; k < 8; k++) rd_chk(5'(k * 4), 8'h00);
        wr(`ABU_OFF_ADDR_HIGH, 8'h12);
        wr(`ABU_OFF_ADDR_LOW, 8'h34);
        bus(1'b1, `ABU_OFF_ADDR_HIGH, 8'hff, 4'h0, q);
        rd_chk(`ABU_OFF_ADDR_HIGH, 8'h12);
        rd_chk(`ABU_OFF_ADDR_LOW, 8'h34);
        wr(`ABU_OFF_IRQ_MASK, 8'h03);
        wr(`ABU_OFF_CTRL_STATUS, 8'h80);
        run <= 1'b1;
        restart;
        wait_req;
        cmp(prev_addr, 16'h1234);
        cmp(siu_out.vector, `ABU_VEC_NORMAL);
        cmp({8'h00, swi_op}, 16'h005a);
        cmp_bit(siu_out.in_break, 1'b1);
        cmp_bit(siu_out.timer_hold, 1'b1);
        cmp_bit(siu_out.status_clear_allow, 1'b0);
        cmp_bit(siu_out.watchdog_disable, 1'b0);
        cmp_bit(irq, 1'b1);
        rd_chk(`ABU_OFF_CTRL_STATUS, 8'hc0);
        wr(`ABU_OFF_CTRL_STATUS, 8'h80);
        end_break;
        rd_chk(`ABU_OFF_IRQ_STATUS, 8'h03);
        rd_chk(`ABU_OFF_IRQ_STATUS, 8'h00);
        cmp_bit(irq, 1'b0);
        restart;
        quiet(40);
        // Operand break in monitor mode, re-armed by a new low byte
        monitor_mode <= 1'b1;
        wr(`ABU_OFF_AUXILIARY, 8'h01);
        wr(`ABU_OFF_FLAG_CTRL, 8'h80);
        wr(`ABU_OFF_ADDR_LOW, 8'h35);
        restart;
        wait_req;
        cmp(prev_addr, 16'h1236);
        cmp(siu_out.vector, `ABU_VEC_MONITOR);
        cmp_bit(siu_out.watchdog_disable, 1'b1);
        cmp_bit(siu_out.status_clear_allow, 1'b1);
        wr(`ABU_OFF_CTRL_STATUS, 8'h80);
        end_break;
        // Software break with the interrupt masked
        wr(`ABU_OFF_IRQ_MASK, 8'h00);
        wr(`ABU_OFF_CTRL_STATUS, 8'h00);
        rd_chk(`ABU_OFF_IRQ_STATUS, 8'h03);
        wr(`ABU_OFF_CTRL_STATUS, 8'h40);
        wait_req;
        cmp({15'h0000, prev_addr[0]}, 16'h0000);
        cmp_bit(irq, 1'b0);
        rd_chk(`ABU_OFF_CTRL_STATUS, 8'h40);
        wr(`ABU_OFF_IRQ_MASK, 8'h01);
        cmp_bit(irq, 1'b1);
        rd_chk(`ABU_OFF_IRQ_STATUS, 8'h01);
        cmp_bit(irq, 1'b0);
        wr(`ABU_OFF_CTRL_STATUS, 8'h00);
        end_break;
        low_power <= 1'b1;
        wr(`ABU_OFF_ADDR_LOW, 8'h34);
        wr(`ABU_OFF_CTRL_STATUS, 8'h80);
        restart;
        quiet(30);
        low_power <= 1'b0;
        wr(`ABU_OFF_CTRL_STATUS, 8'h00);
        restart;
        quiet(30);
        report_and_stop;
    end
endmodule
